/* File: hw/edc_top.sv */
// eight channel transfer controller with register port and two buses
// Summary of operation
// - eight channels, each with own registers
// - transfers use the block's own buses
// - channel serves requests only while enabled
// - size bit selects byte or word
// - direction bit picks RAM-to-peripheral or reverse
// - half bit moves interrupt to mid block
// - null mode adds zero peripheral write to peripheral-to-RAM transfers
// - addressing field picks increment, fixed, indirect
// - mode field picks one-shot, continuous, ping-pong
// - one-shot stops after one block, after both buffers in ping-pong
// - continuous reloads start address each block
// - ping-pong alternates primary and secondary start
// - indirect mode adds peripheral supplied offset
// - manual trigger starts exactly one transfer
// - trigger bit cleared only by hardware
// - seven-bit field selects request line
// - sixteen-bit primary start address per channel
// - sixteen-bit secondary start address per channel
// - count and peripheral address per channel
// - interrupt at block end or half
// - unused control bits read zero
// - block is count plus one transfers
// - read-only flag shows selected start address
// - clear-only peripheral and RAM collision flags
// - last channel reads all ones until first
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module edc_top (
  input  wire  logic                   CLK,
  input  wire  logic                   RESETN,
  input  wire  logic [edc_pkg::AW-1:0] ADDR,
  input  wire  logic [15:0]            WDATA,
  input  wire  logic                   WR,
  input  wire  logic                   RD,
  output       logic [15:0]            RDATA,
  input  wire  logic [127:0]           REQ_LINES,
  input  wire  logic [15:0]            PIND_ADDR,
  input  wire  logic [15:0]            P_RDATA,
  input  wire  logic                   P_WCOL,
  output       edc_pkg::edc_bus_t      PER_BUS,
  input  wire  logic [15:0]            RAM_RDATA,
  input  wire  logic                   RAM_WCOL,
  output       edc_pkg::edc_bus_t      RAM_BUS,
  output       logic [edc_pkg::NCH-1:0] IRQ
);
  import edc_pkg::*;

  edc_cfg_t    cfg_ff [NCH];            // control per channel
  logic [SEL_W-1:0] sel_ff [NCH];       // request line select
  logic [15:0] sta_ff [NCH];            // primary start
  logic [15:0] stb_ff [NCH];            // secondary start
  logic [15:0] pad_ff [NCH];            // peripheral address
  logic [CNT_W-1:0] cnt_ff [NCH];       // transfers minus one
  logic [15:0] ofs_ff [NCH];            // running RAM offset
  logic [10:0] done_ff [NCH];           // transfers done in block
  logic [NCH-1:0] frc_ff;               // manual trigger bits
  logic [NCH-1:0] pend_ff;              // pending requests
  logic [NCH-1:0] prev_ff;              // last request line level
  logic [NCH-1:0] pp_ff;                // ping-pong buffer flag
  logic [NCH-1:0] pcol_ff;              // peripheral collision
  logic [NCH-1:0] xcol_ff;              // RAM collision
  logic [3:0]  lst_ff;                  // last active channel
  edc_st_t     st_ff;                   // engine state
  logic [2:0]  cur_ff;                  // channel being served
  logic        cfrc_ff;                 // served transfer was forced
  edc_bus_t    per_ff;                  // peripheral bus outputs
  edc_bus_t    ram_ff;                  // RAM bus outputs
  logic [NCH-1:0] irq_ff;               // interrupt pulses
  logic [15:0] rdata_ff;                // read data

  logic [NCH-1:0] lvl;                  // selected request levels
  logic [NCH-1:0] on_v;                 // enable bits
  logic [NCH-1:0] frc_wr;               // trigger written this cycle
  logic        gv;                      // some channel may start
  logic [2:0]  gi;                      // channel that starts
  logic        wr_st;                   // last step of a transfer
  logic [10:0] nd;                      // done count after this step
  logic [10:0] blen;                    // transfers per block
  logic [10:0] hpt;                     // half point
  logic        bend;                    // block ends now
  logic        stop;                    // one-shot stops now
  logic        irq_hit;                 // interrupt due now
  logic        cw;                      // channel register write
  logic [2:0]  wch;                     // written channel
  logic [15:0] gbase;                   // start address of grant
  logic [15:0] gaddr;                   // RAM address of grant
  logic [15:0] src;                     // captured source word
  logic [7:0]  sb;                      // captured source byte
  logic [15:0] wd;                      // data to write
  edc_cfg_t    cc;                      // config of current channel
  edc_cfg_t    gc;                      // config of granted channel

  assign cw  = WR && !ADDR[6];
  assign wch = ADDR[5:3];
  assign cc  = cfg_ff[cur_ff];
  assign gc  = cfg_ff[gi];

  // request levels, enables and trigger writes per channel
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      lvl[c]    = REQ_LINES[sel_ff[c]];
      on_v[c]   = cfg_ff[c].on;
      frc_wr[c] = cw && wch == 3'(c) && ADDR[2:0] == REG_REQ
                  && WDATA[BIT_FORCE];
    end
  end

  // fixed priority pick, lowest channel first
  always_comb begin
    gv = 1'b0;
    gi = 3'h0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (pend_ff[c] && on_v[c]) begin
        gv = 1'b1;
        gi = 3'(c);
      end
    end
  end

  // RAM address for the granted channel
  always_comb begin
    gbase = pp_ff[gi] ? stb_ff[gi] : sta_ff[gi];
    if (edc_am_t'(gc.addressing_select) == AM_PIND) begin
      gaddr = gbase + PIND_ADDR;
    end else begin
      gaddr = gbase + ofs_ff[gi];
    end
  end

  // source data and byte pick
  always_comb begin
    src = cc.dir ? RAM_RDATA : P_RDATA;
    sb  = (cc.dir && ram_ff.addr[0]) ? src[15:8] : src[7:0];
    wd  = cc.size ? {sb, sb} : src;
  end

  // block accounting of the transfer in its last step
  always_comb begin
    wr_st   = st_ff == ST_WR;
    nd      = done_ff[cur_ff] + 11'h001;
    blen    = {1'b0, cnt_ff[cur_ff]} + 11'h001;
    hpt     = blen >> 1;
    bend    = wr_st && nd == blen;
    stop    = bend && cc.mode[MD_ONE]
              && (!cc.mode[MD_PP] || pp_ff[cur_ff]);
    if (cc.half && hpt != 11'h000) begin
      irq_hit = wr_st && nd == hpt;
    end else begin
      irq_hit = bend;
    end
  end

  // channel registers: software writes, hardware clears enable
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int c = 0; c < NCH; c++) begin
        cfg_ff[c] <= '0;
        sel_ff[c] <= '0;
        sta_ff[c] <= RST_WORD;
        stb_ff[c] <= RST_WORD;
        pad_ff[c] <= RST_WORD;
        cnt_ff[c] <= '0;
      end
    end else begin
      if (stop) begin
        cfg_ff[cur_ff].on <= 1'b0;
      end
      if (cw) begin
        if (ADDR[2:0] == REG_CTL) begin
          // unused bits are simply not stored
          cfg_ff[wch] <= {WDATA[BIT_ON], WDATA[BIT_SIZE],
                          WDATA[BIT_DIR], WDATA[BIT_HALF],
                          WDATA[BIT_NULL_WRITE_MODE], WDATA[AM_LO+1:AM_LO],
                          WDATA[MD_LO+1:MD_LO]};
        end else if (ADDR[2:0] == REG_REQ) begin
          sel_ff[wch] <= WDATA[SEL_W-1:0];
        end else if (ADDR[2:0] == REG_STA) begin
          sta_ff[wch] <= WDATA;
        end else if (ADDR[2:0] == REG_STB) begin
          stb_ff[wch] <= WDATA;
        end else if (ADDR[2:0] == REG_PAD) begin
          pad_ff[wch] <= WDATA;
        end else if (ADDR[2:0] == REG_CNT) begin
          cnt_ff[wch] <= WDATA[CNT_W-1:0];
        end
      end
    end
  end

  // manual trigger: set by software, cleared by hardware only
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      frc_ff <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (frc_wr[c]) begin
          frc_ff[c] <= 1'b1;
        end else if (wr_st && cfrc_ff && cur_ff == 3'(c)) begin
          frc_ff[c] <= 1'b0;
        end
      end
    end
  end

  // pending requests from line edges and triggers, set wins
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pend_ff <= '0;
      prev_ff <= '0;
    end else begin
      prev_ff <= lvl;
      for (int c = 0; c < NCH; c++) begin
        if (!on_v[c]) begin
          pend_ff[c] <= 1'b0;
        end else if ((lvl[c] && !prev_ff[c]) || frc_wr[c]) begin
          pend_ff[c] <= 1'b1;
        end else if (st_ff == ST_IDLE && gv && gi == 3'(c)) begin
          pend_ff[c] <= 1'b0;
        end
      end
    end
  end

  // transfer engine: read, capture, write on the private buses
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_ff   <= ST_IDLE;
      cur_ff  <= 3'h0;
      cfrc_ff <= 1'b0;
      per_ff  <= '0;
      ram_ff  <= '0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (gv) begin
            cur_ff      <= gi;
            cfrc_ff     <= frc_ff[gi];
            per_ff.addr <= pad_ff[gi];
            ram_ff.addr <= gaddr;
            ram_ff.be   <= gc.size ? (gaddr[0] ? 2'b10 : 2'b01)
                                   : 2'b11;
            per_ff.be   <= gc.size ? 2'b01 : 2'b11;
            ram_ff.rd   <= gc.dir;
            per_ff.rd   <= !gc.dir;
            st_ff       <= ST_RD;
          end
        end
        ST_RD: begin
          ram_ff.rd <= 1'b0;
          per_ff.rd <= 1'b0;
          st_ff     <= ST_CAP;
        end
        ST_CAP: begin
          if (cc.dir) begin
            per_ff.wr    <= 1'b1;
            per_ff.wdata <= wd;
          end else begin
            ram_ff.wr    <= 1'b1;
            ram_ff.wdata <= wd;
            if (cc.null_write_mode) begin
              per_ff.wr    <= 1'b1;
              per_ff.wdata <= 16'h0000;
            end
          end
          st_ff <= ST_WR;
        end
        default: begin
          ram_ff.wr <= 1'b0;
          per_ff.wr <= 1'b0;
          st_ff     <= ST_IDLE;
        end
      endcase
    end
  end

  // offsets, block counters and ping-pong flag
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pp_ff <= '0;
      for (int c = 0; c < NCH; c++) begin
        ofs_ff[c]  <= RST_WORD;
        done_ff[c] <= 11'h000;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (cw && wch == 3'(c) && ADDR[2:0] == REG_CTL) begin
          // new setup restarts the block from the primary start
          ofs_ff[c]  <= RST_WORD;
          done_ff[c] <= 11'h000;
          pp_ff[c]   <= 1'b0;
        end else if (wr_st && cur_ff == 3'(c)) begin
          if (bend) begin
            ofs_ff[c]  <= RST_WORD;
            done_ff[c] <= 11'h000;
            if (cc.mode[MD_PP]) begin
              pp_ff[c] <= !pp_ff[c];
            end
          end else begin
            done_ff[c] <= nd;
            if (edc_am_t'(cc.addressing_select) == AM_INC) begin
              ofs_ff[c] <= ofs_ff[c] + (cc.size ? 16'h0001
                                                : 16'h0002);
            end
          end
        end
      end
    end
  end

  // collision flags, interrupt pulses and last channel
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pcol_ff <= '0;
      xcol_ff <= '0;
      irq_ff  <= '0;
      lst_ff  <= RST_LAST_ACTIVE_CHANNEL;
    end else begin
      irq_ff <= '0;
      if (irq_hit) begin
        irq_ff[cur_ff] <= 1'b1;
      end
      if (wr_st) begin
        lst_ff <= {1'b0, cur_ff};
      end
      for (int c = 0; c < NCH; c++) begin
        // a collision beside a clearing write still sets
        if (wr_st && cur_ff == 3'(c) && per_ff.wr && P_WCOL) begin
          pcol_ff[c] <= 1'b1;
        end else if (WR && ADDR == OFS_STAT0 && !WDATA[8+c]) begin
          pcol_ff[c] <= 1'b0;
        end
        if (wr_st && cur_ff == 3'(c) && ram_ff.wr && RAM_WCOL) begin
          xcol_ff[c] <= 1'b1;
        end else if (WR && ADDR == OFS_STAT0 && !WDATA[c]) begin
          xcol_ff[c] <= 1'b0;
        end
      end
    end
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_ff <= RST_WORD;
    end else if (RD) begin
      rdata_ff <= RST_WORD;
      if (ADDR == OFS_STAT0) begin
        rdata_ff <= {pcol_ff, xcol_ff};
      end else if (ADDR == OFS_STAT1) begin
        rdata_ff <= {4'h0, lst_ff, pp_ff};
      end else if (!ADDR[6] && ADDR[2:0] == REG_CTL) begin
        rdata_ff <= {cfg_ff[wch].on, cfg_ff[wch].size,
                     cfg_ff[wch].dir, cfg_ff[wch].half,
                     cfg_ff[wch].null_write_mode, 5'h00, cfg_ff[wch].addressing_select,
                     2'h0, cfg_ff[wch].mode};
      end else if (!ADDR[6] && ADDR[2:0] == REG_REQ) begin
        rdata_ff <= {frc_ff[wch], 8'h00, sel_ff[wch]};
      end else if (!ADDR[6] && ADDR[2:0] == REG_STA) begin
        rdata_ff <= sta_ff[wch];
      end else if (!ADDR[6] && ADDR[2:0] == REG_STB) begin
        rdata_ff <= stb_ff[wch];
      end else if (!ADDR[6] && ADDR[2:0] == REG_PAD) begin
        rdata_ff <= pad_ff[wch];
      end else if (!ADDR[6] && ADDR[2:0] == REG_CNT) begin
        rdata_ff <= {6'h00, cnt_ff[wch]};
      end
    end
  end

  assign RDATA   = rdata_ff;
  assign PER_BUS = per_ff;
  assign RAM_BUS = ram_ff;
  assign IRQ     = irq_ff;

  // checks on the engine
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence rd_phase;
    (ram_ff.rd || per_ff.rd);
  endsequence
  sequence wr_phase;
    ##2 (ram_ff.wr || per_ff.wr) ##1 !(ram_ff.wr || per_ff.wr);
  endsequence

  rd_then_wr_a: assert property (rd_phase |-> wr_phase)
    else $error("read not followed by one write");
  grant_enabled_a: assert property (st_ff == ST_IDLE && gv
    |=> st_ff == ST_RD && cfg_ff[cur_ff].on)
    else $error("disabled channel started");
  low_first_a: assert property (gv |->
    ((pend_ff & on_v) & ((8'h01 << gi) - 8'h01)) == 8'h00)
    else $error("lower pending channel skipped");
  dir_write_a: assert property (wr_st && cc.dir
    |-> per_ff.wr && !ram_ff.wr)
    else $error("wrong write target");
  null_write_a: assert property (wr_st && !cc.dir && cc.null_write_mode
    |-> per_ff.wr && per_ff.wdata == 16'h0000)
    else $error("null write missing");
  last_chan_a: assert property (wr_st
    |=> lst_ff == {1'b0, $past(cur_ff)})
    else $error("last channel not updated");
  force_clr_a: assert property (wr_st && cfrc_ff
    |=> !frc_ff[cur_ff])
    else $error("trigger not cleared");
  irq_cause_a: assert property ((|irq_ff) |-> $past(wr_st))
    else $error("interrupt without transfer");
  byte_lane_a: assert property (ram_ff.wr && cc.size
    |-> ram_ff.be != 2'b11)
    else $error("byte transfer on both lanes");
endmodule : edc_top

/* File: hw/edc_pkg.sv */
// shared constants and types of the eight channel transfer controller
package edc_pkg;
  localparam int         NCH       = 8;     // number of channels
  localparam int         AW        = 7;     // register port address width
  // register index inside a channel block, channel number in ADDR[5:3]
  localparam logic [2:0] REG_CTL   = 3'h0;  // channel_control
  localparam logic [2:0] REG_REQ   = 3'h1;  // channel_request_select
  localparam logic [2:0] REG_STA   = 3'h2;  // ram_start_primary
  localparam logic [2:0] REG_STB   = 3'h3;  // ram_start_secondary
  localparam logic [2:0] REG_PAD   = 3'h4;  // periph_address
  localparam logic [2:0] REG_CNT   = 3'h5;  // count_register
  localparam logic [6:0] OFS_STAT0 = 7'h40; // collision_status
  localparam logic [6:0] OFS_STAT1 = 7'h41; // channel_history_status
  // control field positions
  localparam int BIT_ON    = 15;
  localparam int BIT_SIZE  = 14;
  localparam int BIT_DIR   = 13;
  localparam int BIT_HALF  = 12;
  localparam int BIT_NULL_WRITE_MODE = 11;
  localparam int AM_LO     = 4;
  localparam int MD_LO     = 0;
  localparam int BIT_FORCE = 15;
  localparam int SEL_W     = 7;
  localparam int CNT_W     = 10;
  localparam int MD_ONE    = 0;   // one-shot bit inside mode
  localparam int MD_PP     = 1;   // ping-pong bit inside mode
  // reset values
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [3:0]  RST_LAST_ACTIVE_CHANNEL = 4'hf;
  // addressing_select codes
  typedef enum logic [1:0] {
    AM_INC  = 2'b00,
    AM_FIX  = 2'b01,
    AM_PIND = 2'b10,
    AM_RSV  = 2'b11
  } edc_am_t;
  // engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD   = 2'b01,
    ST_CAP  = 2'b10,
    ST_WR   = 2'b11
  } edc_st_t;
  // channel_control fields
  typedef struct packed {
    logic       on;
    logic       size;
    logic       dir;
    logic       half;
    logic       null_write_mode;
    logic [1:0] addressing_select;
    logic [1:0] mode;
  } edc_cfg_t;
  // one side of the transfer bus
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [1:0]  be;
  } edc_bus_t;
endpackage : edc_pkg

/* File: dv/edc_partner.sv */
// far side model: one peripheral that answers reads with an address pattern, and the transfer RAM
`timescale 1ns/1ps
module edc_partner (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire edc_pkg::edc_bus_t per_bus,
  input  wire edc_pkg::edc_bus_t ram_bus,
  input  wire logic              col_en,
  output      logic [15:0]       p_rdata,
  output      logic [15:0]       ram_rdata,
  output      logic              p_wcol,
  output      logic              ram_wcol
);
  import edc_pkg::*;
  logic [15:0] mem [0:255];  // transfer RAM words, buffers live here only
  logic [15:0] ram_wa;       // last RAM write address
  logic [15:0] ram_wd;       // last RAM write data
  logic [15:0] ram_ra;       // last RAM read address
  logic [15:0] per_wd;       // last peripheral write data
  logic [1:0]  per_be;       // last peripheral byte enables
  int          ram_wn = 0;   // RAM writes seen
  int          per_wn = 0;   // peripheral writes seen
  // empty RAM at start, so no unknown is ever read back
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
    end
  end
  // collision flags only beside a write strobe
  assign p_wcol   = col_en & per_bus.wr;
  assign ram_wcol = col_en & ram_bus.wr;
  // peripheral: data the cycle after a read, scrambled otherwise
  always @(posedge clk) begin
    if (!resetn) begin
      p_rdata <= 16'h3c3c;
    end else if (per_bus.rd) begin
      p_rdata <= {per_bus.addr[7:0] ^ 8'ha5, per_bus.addr[7:0]};
    end else begin
      p_rdata <= ~p_rdata;
    end
    if (per_bus.wr) begin
      per_wd <= per_bus.wdata;
      per_be <= per_bus.be;
      per_wn <= per_wn + 1;
    end
  end
  // RAM: word array decoded on the RAM bus alone
  always @(posedge clk) begin
    if (!resetn) begin
      ram_rdata <= 16'hc3c3;
    end else if (ram_bus.rd) begin
      ram_rdata <= mem[ram_bus.addr[8:1]];
      ram_ra    <= ram_bus.addr;
    end else begin
      ram_rdata <= ~ram_rdata;
    end
    if (ram_bus.wr) begin
      if (ram_bus.be[0]) mem[ram_bus.addr[8:1]][7:0]  <= ram_bus.wdata[7:0];
      if (ram_bus.be[1]) mem[ram_bus.addr[8:1]][15:8] <= ram_bus.wdata[15:8];
      ram_wa <= ram_bus.addr;
      ram_wd <= ram_bus.wdata;
      ram_wn <= ram_wn + 1;
    end
  end
endmodule : edc_partner

/* File: dv/edc_top_bench.sv */
// self-checking bench of the eight channel transfer controller
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module edc_top_bench;
  import edc_pkg::*;
  logic           clk, resetn, wr, rd, p_wcol, ram_wcol, col_en;
  logic [AW-1:0]  addr;             // register address
  logic [15:0]    wdata, rdata;     // register data
  logic [127:0]   req_lines;        // peripheral request lines
  logic [15:0]    pind_addr;        // peripheral supplied offset
  logic [15:0]    p_rdata, ram_rdata;
  edc_bus_t       per_bus, ram_bus; // both transfer buses
  logic [NCH-1:0] irq;              // channel interrupts
  int             err_total = 0;
  int             samples_checked = 0;
  int             irq_cnt [NCH] = '{default: 0}; // pulses per channel
  edc_top uut (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .REQ_LINES(req_lines),
    .PIND_ADDR(pind_addr), .P_RDATA(p_rdata), .P_WCOL(p_wcol),
    .PER_BUS(per_bus), .RAM_RDATA(ram_rdata), .RAM_WCOL(ram_wcol),
    .RAM_BUS(ram_bus), .IRQ(irq));
  edc_partner far (.clk(clk), .resetn(resetn), .per_bus(per_bus),
    .ram_bus(ram_bus), .col_en(col_en), .p_rdata(p_rdata),
    .ram_rdata(ram_rdata), .p_wcol(p_wcol), .ram_wcol(ram_wcol));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // count interrupt pulses of every channel
  always @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      irq_cnt[i] <= irq_cnt[i] + int'(irq[i]);
    end
  end
  // verdict and end of run
  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // register address of one channel register
  function automatic logic [AW-1:0] ra(input int c, input logic [2:0] i);
    return {1'b0, c[2:0], i};
  endfunction : ra
  // one write cycle, then a quiet cycle
  task automatic reg_wr(input logic [AW-1:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask : reg_wr
  // read cycle, data compared in the cycle after the strobe
  task automatic reg_chk(input logic [AW-1:0] a, input logic [15:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    `CHK(rdata, e)
    @(posedge clk);
  endtask : reg_chk
  // program one channel, control last since it restarts the block
  task automatic cfg(input int c, input logic [15:0] ctl, sel, start_addr_primary, stb, n);
    reg_wr(ra(c, REG_REQ), sel);
    reg_wr(ra(c, REG_STA), start_addr_primary);
    reg_wr(ra(c, REG_STB), stb);
    reg_wr(ra(c, REG_PAD), 16'h0020);
    reg_wr(ra(c, REG_CNT), n);
    reg_wr(ra(c, REG_CTL), ctl);
  endtask : cfg
  // one-cycle rise on request lines, then room for two transfers
  task automatic pulse(input logic [127:0] m);
    req_lines <= m;
    @(posedge clk);
    req_lines <= '0;
    repeat (16) @(posedge clk);
  endtask : pulse
  // hang guard
  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    complete_run();
  end
  // main sequence
  initial begin
    {resetn, wr, rd, col_en} = 4'h0;
    {addr, wdata, req_lines, pind_addr} = '0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    reg_chk(OFS_STAT1, 16'h0f00);
    reg_chk(ra(0, REG_CTL), 16'h0000);
    // register widths, unused bits, unmapped place
    reg_wr(ra(7, REG_CTL), 16'h7fff);
    reg_chk(ra(7, REG_CTL), 16'h7833);
    reg_wr(ra(7, REG_REQ), 16'h7fff);
    reg_chk(ra(7, REG_REQ), 16'h007f);
    reg_wr(ra(7, REG_STB), 16'hffff);
    reg_chk(ra(7, REG_STB), 16'hffff);
    reg_wr(ra(7, REG_CNT), 16'hffff);
    reg_chk(ra(7, REG_CNT), 16'h03ff);
    reg_wr(ra(7, 3'h6), 16'hffff);
    reg_chk(ra(7, 3'h6), 16'h0000);
    for (int c = 0; c < NCH; c++) reg_wr(ra(c, REG_STA), 16'h5a00 | 16'(c));
    for (int c = 0; c < NCH; c++)
      reg_chk(ra(c, REG_STA), 16'h5a00 | 16'(c));
    // word, peripheral to RAM, increment, one-shot, two per block
    cfg(0, 16'h8001, 16'h0000, 16'h0100, 16'h0000, 16'h0001);
    reg_chk(ra(0, REG_PAD), 16'h0020);
    pulse(128'h1);
    `CHK(far.ram_wa, 16'h0100)
    `CHK(far.ram_wd, 16'h8520)
    `CHK(irq_cnt[0], 0)
    pulse(128'h1);
    `CHK(far.ram_wa, 16'h0102)
    `CHK(irq_cnt[0], 1)
    reg_chk(ra(0, REG_CTL), 16'h0001);
    reg_chk(OFS_STAT1, 16'h0000);
    pulse(128'h1);
    `CHK(far.ram_wn, 2)
    // byte, RAM to peripheral, continuous, manual trigger
    cfg(4, 16'he000, 16'h0005, 16'h0101, 16'h0000, 16'h0000);
    reg_wr(ra(4, REG_REQ), 16'h8005);
    repeat (16) @(posedge clk);
    `CHK(far.ram_ra, 16'h0101)
    `CHK(far.per_wd[7:0], 8'h85)
    `CHK(far.per_be, 2'b01)
    `CHK(far.per_wn, 1)
    reg_chk(ra(4, REG_REQ), 16'h0005);
    reg_wr(ra(4, REG_REQ), 16'h8005);
    reg_wr(ra(4, REG_REQ), 16'h0005);
    repeat (16) @(posedge clk);
    `CHK(far.per_wn, 2)
    `CHK(far.ram_ra, 16'h0101)
    `CHK(irq_cnt[4], 2)
    reg_wr(ra(4, REG_CTL), 16'h0000);
    // two channels asked at once, lower one first
    cfg(1, 16'h8000, 16'h0001, 16'h0180, 16'h0000, 16'h0000);
    cfg(2, 16'h8000, 16'h0002, 16'h01c0, 16'h0000, 16'h0000);
    pulse(128'h6);
    `CHK(far.ram_wn, 4)
    reg_chk(OFS_STAT1, 16'h0200);
    // continuous ping-pong, one transfer per block
    cfg(3, 16'h8002, 16'h0003, 16'h0200, 16'h0300, 16'h0000);
    pulse(128'h8);
    `CHK(far.ram_wa, 16'h0200)
    reg_chk(OFS_STAT1, 16'h0308);
    pulse(128'h8);
    `CHK(far.ram_wa, 16'h0300)
    reg_chk(OFS_STAT1, 16'h0300);
    // half-block interrupt over a block of four
    cfg(5, 16'h9000, 16'h0005, 16'h0240, 16'h0000, 16'h0003);
    for (int k = 0; k < 4; k++) begin
      pulse(128'h20);
      `CHK(irq_cnt[5], int'(k >= 1))
    end
    // null write with indirect address, both writes collide
    pind_addr <= 16'h0010;
    col_en    <= 1'b1;
    cfg(6, 16'h8821, 16'h0006, 16'h0100, 16'h0000, 16'h0000);
    pulse(128'h40);
    `CHK(far.ram_wa, 16'h0110)
    `CHK(far.per_wn, 3)
    col_en <= 1'b0;
    reg_chk(OFS_STAT0, 16'h4040);
    reg_wr(OFS_STAT0, 16'h0000);
    reg_chk(OFS_STAT0, 16'h0000);
    complete_run();
  end
endmodule : edc_top_bench
